/* File: shared/iopc_pkg.sv */
// Summary of operation
// - A logic change on any pin enabled for pin-change detection sets the pin-change flag, bit 5 of the flag register.
// - A set pin-change flag with the global enable and either group enable set requests the pin-change vector.
// - The pin-change flag clears when its handler is entered, and when software writes a one to bit 5 of the flag clear register.
// - The low bits 4:0 of the flag register are reserved and always read as zero.
// - Each bit of the low mask enables detection on its port A pin while group enable 1 is set; a cleared bit disables it.
// - High mask bits for pins 8 to 11 are qualified by group enable 0, those for pins 12 to 15 by group enable 1.
// - The input synchroniser holds the pin value while the clock is low and loads it into the pin input register at the next rising edge.
// - A pin value driven by software reaches the pin input register exactly one clock after the output write.
// - In the deep sleep modes a clamp forces each pin's digital input to ground ahead of the input stage.
// - The clamp is overridden on enabled external interrupt pins and by other alternate functions, but not on disabled external interrupt pins.
// - A disabled external interrupt pin sensing any edge or rising edges that is high during a clamping sleep gets its flag set on wake-up.
// - Software-enabled pull-ups are off while the device is held in reset.
// - With the pull-up disable bit (bit 6 of the control register) set, every pull-up is off whatever the pin setting.
// - Port A pin 1 has its input enable overridden when its mask and group enable are set, or when its analog input disable is set.
// - Vectors are ranked by position, a lower vector having a higher priority, and each source has its own vector.
package iopc_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NPINS  = 16;

   // Register indices; the byte address is four times the index.
   localparam logic [5:0] IDX_PORT_B_INPUT  = 6'h16;
   localparam logic [5:0] IDX_PORT_B_DIR    = 6'h17;
   localparam logic [5:0] IDX_PORT_B_OUTPUT = 6'h18;
   localparam logic [5:0] IDX_PORT_A_INPUT  = 6'h19;
   localparam logic [5:0] IDX_PORT_A_DIR    = 6'h1a;
   localparam logic [5:0] IDX_PORT_A_OUTPUT = 6'h1b;
   localparam logic [5:0] IDX_MASK_HIGH     = 6'h22;
   localparam logic [5:0] IDX_MASK_LOW      = 6'h23;
   localparam logic [5:0] IDX_CORE_CONTROL  = 6'h35;
   localparam logic [5:0] IDX_FLAG_STATUS   = 6'h3a;
   localparam logic [5:0] IDX_GROUP_ENABLE  = 6'h3b;
   localparam logic [5:0] IDX_IRQ_ENABLE    = 6'h3c;
   localparam logic [5:0] IDX_FLAG_CLEAR    = 6'h3d;
   localparam logic [5:0] IDX_EXT_CONTROL   = 6'h3e;
   localparam logic [5:0] IDX_CORE_STATUS   = 6'h3f;

   // Reset values.
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [7:0] RST_MASK_HIGH = 8'hff;
   localparam logic [7:0] RST_MASK_LOW  = 8'hc8;
   localparam logic [7:0] STATUS_MASK   = 8'h60;

   // Field positions.
   localparam int BIT_PC_FLAG  = 5;
   localparam int BIT_EXT_FLAG = 6;
   localparam int BIT_PUD      = 6;
   localparam int BIT_GE1      = 4;
   localparam int BIT_GE0      = 5;
   localparam int BIT_GIE      = 7;
   localparam int BIT_EXT_EN   = 0;
   localparam int BIT_SENSE_LO = 1;
   localparam int BIT_SENSE_HI = 2;
   localparam int BIT_AN1_DIS  = 3;
   localparam int PIN_PA1      = 1;
   localparam int EXT_PIN      = 2;

   // External interrupt sense modes.
   localparam logic [1:0] SENSE_OFF  = 2'h0;
   localparam logic [1:0] SENSE_ANY  = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;

   // Vector numbers, lower is more urgent.
   localparam logic [1:0] VEC_NONE = 2'h0;
   localparam logic [1:0] VEC_EXT  = 2'h1;
   localparam logic [1:0] VEC_PC   = 2'h2;

endpackage

/* File: hdl/iopc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module iopc_sync
#(
   parameter int WIDTH = 16
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] held;

   // Holding stage: captures the pin as the clock falls, like a latch
   // that closes when the clock goes low.
   always_ff @(negedge pclk or negedge presetn)
   begin
      if (!presetn)
         held <= '0;
      else
         held <= async_in;
   end

   // Pin input register: loads the held value at the next rising edge.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sync_out <= '0;
      else
         sync_out <= held;
   end

endmodule
`default_nettype wire

/* File: hdl/iopc_pcdet.sv */
`timescale 1ns/1ps
`default_nettype none
module iopc_pcdet
#(
   parameter int WIDTH = 16
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] pin_val,
   input  wire logic [WIDTH-1:0] enable,
   output logic      [WIDTH-1:0] changed,
   output logic                  change_req
);

   logic [WIDTH-1:0] prev;

   // Keeps each synchronised pin one clock earlier.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prev <= '0;
      else
         prev <= pin_val;
   end

   // Any enabled difference forms one request.
   assign changed    = pin_val ^ prev;
   assign change_req = |(changed & enable);

endmodule
`default_nettype wire

/* File: hdl/iopc_top.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module iopc_top
(
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [iopc_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [iopc_pkg::DATA_W-1:0]  pwdata,
   output logic      [iopc_pkg::DATA_W-1:0]  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic [iopc_pkg::NPINS-1:0]   pin_in,
   output logic      [iopc_pkg::NPINS-1:0]   pin_out,
   output logic      [iopc_pkg::NPINS-1:0]   pin_oe_n,
   output logic      [iopc_pkg::NPINS-1:0]   pullup_en,
   input  wire logic                         sleep_clamp,
   input  wire logic                         vector_ack,
   output logic                              vector_req,
   output logic      [1:0]                   vector_num,
   output logic                              irq
);
   import iopc_pkg::*;

   logic [7:0]       port_a_output;
   logic [7:0]       port_a_direction;
   logic [7:0]       port_b_output;
   logic [7:0]       port_b_direction;
   logic [7:0]       pin_change_mask_low;
   logic [7:0]       pin_change_mask_high;
   logic [7:0]       core_control;
   logic [7:0]       general_interrupt_mask;
   logic [7:0]       irq_enable;
   logic [7:0]       ext_control;
   logic [7:0]       core_status_register;
   logic [7:0]       flag_status;
   logic [7:0]       next_flag_status;
   logic [7:0]       flag_clear;
   logic [NPINS-1:0] next_out;
   logic [NPINS-1:0] next_dir;
   logic             next_pud;
   logic [NPINS-1:0] pc_en;
   logic [NPINS-1:0] override;
   logic [NPINS-1:0] pin_gated;
   logic [NPINS-1:0] pin_val;
   logic [NPINS-1:0] changed;
   logic             pc_req;
   logic             ext_req;
   logic             ext_pend;
   logic             pc_pend;
   logic             ge0;
   logic             ge1;
   logic             ext_en;
   logic             an1_dis;
   logic [1:0]       sense;
   logic             access;
   logic             wr_go;
   logic             mapped;
   logic [7:0]       rd_byte;

   // True when the bus address selects the register at this index.
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [5:0]        idx);
      return a == {idx, 2'b00};
   endfunction

   // Loose control fields.
   assign ge0     = general_interrupt_mask[BIT_GE0];
   assign ge1     = general_interrupt_mask[BIT_GE1];
   assign ext_en  = ext_control[BIT_EXT_EN];
   assign an1_dis = ext_control[BIT_AN1_DIS];
   assign sense   = ext_control[BIT_SENSE_HI:BIT_SENSE_LO];

   // Bus handshake terms; a write lands only at the completing edge.
   assign access = psel & penable & pready;
   assign wr_go  = access & pwrite;

   // Per-pin detection enables: port A by group 1, pins 8-11 by
   // group 0 and pins 12-15 by group 1.
   assign pc_en = {pin_change_mask_high[7:4] & {4{ge1}},
                   pin_change_mask_high[3:0] & {4{ge0}},
                   pin_change_mask_low & {8{ge1}}};

   // Input enable: the sleep clamp grounds the input unless an
   // alternate function overrides it.
   always_comb
   begin
      override = pc_en;
      override[PIN_PA1] = pc_en[PIN_PA1] | an1_dis;
      override[EXT_PIN] = pc_en[EXT_PIN] | ext_en;
      for (int i = 0; i < NPINS; i++)
      begin
         if (override[i])
            pin_gated[i] = pin_in[i] & ~(i == PIN_PA1 && an1_dis);
         else
            pin_gated[i] = pin_in[i] & ~sleep_clamp;
      end
   end

   iopc_sync #(.WIDTH(NPINS)) u_sync
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (pin_gated),
      .sync_out (pin_val)
   );

   iopc_pcdet #(.WIDTH(NPINS)) u_pcdet
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin_val    (pin_val),
      .enable     (pc_en),
      .changed    (changed),
      .change_req (pc_req)
   );

   // External pin edges set their flag even while the request is
   // disabled, so a clamp release is seen as a change.
   always_comb
   begin
      case (sense)
         SENSE_ANY:  ext_req = changed[EXT_PIN];
         SENSE_FALL: ext_req = changed[EXT_PIN] & ~pin_val[EXT_PIN];
         SENSE_RISE: ext_req = changed[EXT_PIN] & pin_val[EXT_PIN];
         default:    ext_req = 1'b0;
      endcase
   end

   // Next port values, including the toggle on a write to the input
   // address.
   always_comb
   begin
      next_out = {port_b_output, port_a_output};
      next_dir = {port_b_direction, port_a_direction};
      next_pud = core_control[BIT_PUD];
      if (wr_go && hit(paddr, IDX_PORT_A_OUTPUT))
         next_out[7:0] = pwdata[7:0];
      else if (wr_go && hit(paddr, IDX_PORT_A_INPUT))
         next_out[7:0] = port_a_output ^ pwdata[7:0];
      if (wr_go && hit(paddr, IDX_PORT_B_OUTPUT))
         next_out[15:8] = pwdata[7:0];
      else if (wr_go && hit(paddr, IDX_PORT_B_INPUT))
         next_out[15:8] = port_b_output ^ pwdata[7:0];
      if (wr_go && hit(paddr, IDX_PORT_A_DIR))
         next_dir[7:0] = pwdata[7:0];
      if (wr_go && hit(paddr, IDX_PORT_B_DIR))
         next_dir[15:8] = pwdata[7:0];
      if (wr_go && hit(paddr, IDX_CORE_CONTROL))
         next_pud = pwdata[BIT_PUD];
   end

   // Port registers; the pins are driven straight from them.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_a_output    <= RST_ZERO;
         port_b_output    <= RST_ZERO;
         port_a_direction <= RST_ZERO;
         port_b_direction <= RST_ZERO;
         core_control     <= RST_ZERO;
         pin_out          <= '0;
         pin_oe_n         <= '1;
         pullup_en        <= '0;
      end
      else
      begin
         port_a_output    <= next_out[7:0];
         port_b_output    <= next_out[15:8];
         port_a_direction <= next_dir[7:0];
         port_b_direction <= next_dir[15:8];
         core_control     <= {1'b0, next_pud, 6'h00};
         pin_out          <= next_out;
         pin_oe_n         <= ~next_dir;
         pullup_en        <= ~next_dir & next_out & {NPINS{~next_pud}};
      end
   end

   // Mask and enable registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_change_mask_low    <= RST_MASK_LOW;
         pin_change_mask_high   <= RST_MASK_HIGH;
         general_interrupt_mask <= RST_ZERO;
         irq_enable             <= RST_ZERO;
         ext_control            <= RST_ZERO;
         core_status_register   <= RST_ZERO;
      end
      else if (wr_go)
      begin
         if (hit(paddr, IDX_MASK_LOW))
            pin_change_mask_low <= pwdata[7:0];
         else if (hit(paddr, IDX_MASK_HIGH))
            pin_change_mask_high <= pwdata[7:0];
         else if (hit(paddr, IDX_GROUP_ENABLE))
            general_interrupt_mask <= pwdata[7:0] & {2'b00, 2'b11, 4'h0};
         else if (hit(paddr, IDX_IRQ_ENABLE))
            irq_enable <= pwdata[7:0] & STATUS_MASK;
         else if (hit(paddr, IDX_EXT_CONTROL))
            ext_control <= {4'h0, pwdata[3:0]};
         else if (hit(paddr, IDX_CORE_STATUS))
            core_status_register <= {pwdata[BIT_GIE], 7'h00};
      end
   end

   // Clearing sources: a one written to the clear register, or entry
   // to the handler of the vector on offer.
   always_comb
   begin
      flag_clear = 8'h00;
      if (wr_go && hit(paddr, IDX_FLAG_CLEAR))
         flag_clear = pwdata[7:0];
      if (vector_ack && vector_req && vector_num == VEC_PC)
         flag_clear[BIT_PC_FLAG] = 1'b1;
      if (vector_ack && vector_req && vector_num == VEC_EXT)
         flag_clear[BIT_EXT_FLAG] = 1'b1;
      next_flag_status = flag_status & ~flag_clear;
      next_flag_status[BIT_PC_FLAG] = next_flag_status[BIT_PC_FLAG]
                                      | pc_req;
      next_flag_status[BIT_EXT_FLAG] = next_flag_status[BIT_EXT_FLAG]
                                       | ext_req;
      next_flag_status = next_flag_status & STATUS_MASK;
   end

   // Pending vectors, gated by the global and source enables.
   assign pc_pend  = flag_status[BIT_PC_FLAG] & core_status_register[BIT_GIE]
                     & (ge0 | ge1);
   assign ext_pend = flag_status[BIT_EXT_FLAG]
                     & core_status_register[BIT_GIE] & ext_en;

   // Sticky flags, vector request and interrupt line.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_status <= RST_ZERO;
         vector_req  <= 1'b0;
         vector_num  <= VEC_NONE;
         irq         <= 1'b0;
      end
      else
      begin
         flag_status <= next_flag_status;
         vector_req  <= ext_pend | pc_pend;
         if (ext_pend)
            vector_num <= VEC_EXT;
         else if (pc_pend)
            vector_num <= VEC_PC;
         else
            vector_num <= VEC_NONE;
         irq <= |(next_flag_status & irq_enable);
      end
   end

   // Read data for the addressed register.
   always_comb
   begin
      mapped  = 1'b1;
      rd_byte = 8'h00;
      if (hit(paddr, IDX_PORT_A_INPUT))
         rd_byte = pin_val[7:0];
      else if (hit(paddr, IDX_PORT_B_INPUT))
         rd_byte = pin_val[15:8];
      else if (hit(paddr, IDX_PORT_A_OUTPUT))
         rd_byte = port_a_output;
      else if (hit(paddr, IDX_PORT_B_OUTPUT))
         rd_byte = port_b_output;
      else if (hit(paddr, IDX_PORT_A_DIR))
         rd_byte = port_a_direction;
      else if (hit(paddr, IDX_PORT_B_DIR))
         rd_byte = port_b_direction;
      else if (hit(paddr, IDX_MASK_LOW))
         rd_byte = pin_change_mask_low;
      else if (hit(paddr, IDX_MASK_HIGH))
         rd_byte = pin_change_mask_high;
      else if (hit(paddr, IDX_CORE_CONTROL))
         rd_byte = core_control;
      else if (hit(paddr, IDX_FLAG_STATUS))
         rd_byte = flag_status;
      else if (hit(paddr, IDX_GROUP_ENABLE))
         rd_byte = general_interrupt_mask;
      else if (hit(paddr, IDX_IRQ_ENABLE))
         rd_byte = irq_enable;
      else if (hit(paddr, IDX_EXT_CONTROL))
         rd_byte = ext_control;
      else if (hit(paddr, IDX_CORE_STATUS))
         rd_byte = core_status_register;
      else if (!hit(paddr, IDX_FLAG_CLEAR))
         mapped = 1'b0;
   end

   // Bus answer: one access cycle, data registered from the setup.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (psel && !penable && !pwrite)
            prdata <= {24'h000000, rd_byte};
         else
            prdata <= '0;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_pc_flag_set: assert property (pc_req |=> flag_status[BIT_PC_FLAG])
      else $error("Pin change did not set the flag.");
   a_pc_vector: assert property (pc_pend && !ext_pend |=>
      vector_req && vector_num == VEC_PC)
      else $error("Pending pin change not offered as its vector.");
   a_ack_clear: assert property (vector_ack && vector_req
      && vector_num == VEC_PC && !pc_req |=> !flag_status[BIT_PC_FLAG])
      else $error("Handler entry did not clear the flag.");
   a_w1c_clear: assert property (wr_go && hit(paddr, IDX_FLAG_CLEAR)
      && pwdata[BIT_PC_FLAG] && !pc_req |=> !flag_status[BIT_PC_FLAG])
      else $error("Writing one did not clear the flag.");
   a_reserved_zero: assert property (psel && !penable && !pwrite
      && hit(paddr, IDX_FLAG_STATUS) |=> prdata[4:0] == 5'h00)
      else $error("Reserved flag bits read nonzero.");
   a_low_gate: assert property (!ge1 |-> pc_en[7:0] == 8'h00
      && pc_en[15:12] == 4'h0)
      else $error("Group 1 pins enabled without group enable.");
   a_high_gate: assert property (!ge0 |-> pc_en[11:8] == 4'h0)
      else $error("Group 0 pins enabled without group enable.");
   a_clamp_ground: assert property (sleep_clamp |->
      (pin_gated & ~override) == '0)
      else $error("Clamped input not grounded in sleep.");
   a_pullup_off: assert property (core_control[BIT_PUD] |->
      pullup_en == '0)
      else $error("Pull-up on while disabled.");
   a_pa1_override: assert property (an1_dis || pc_en[PIN_PA1] |->
      override[PIN_PA1])
      else $error("Pin 1 input override missing.");
   a_change_or: assert property (|((pin_val ^ $past(pin_val)) & pc_en)
      |=> flag_status[BIT_PC_FLAG])
      else $error("Enabled change did not reach the flag.");
   a_ext_first: assert property (ext_pend |=> vector_num == VEC_EXT)
      else $error("Lower vector not given priority.");

   c_pc_flag: cover property (pc_req ##1 flag_status[BIT_PC_FLAG]);
   c_pc_vector: cover property (vector_req && vector_num == VEC_PC
      ##[1:4] vector_ack);
   c_wake_ext: cover property ($fell(sleep_clamp) && !ext_en
      ##[1:3] flag_status[BIT_EXT_FLAG]);
   c_both_pending: cover property (ext_pend && pc_pend);

endmodule
`default_nettype wire

/* File: test/iopc_board.sv */
`timescale 1ns/1ps
`default_nettype none
module iopc_board
   import iopc_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic [NPINS-1:0] pin_out,
   input  wire logic [NPINS-1:0] pin_oe_n,
   input  wire logic [NPINS-1:0] pullup_en,
   input  wire logic [NPINS-1:0] board_val,
   input  wire logic [NPINS-1:0] board_en,
   output logic      [NPINS-1:0] pin_in
);
   logic [NPINS-1:0] float_pat = '0;
   // An undriven pin with no pull-up wanders every cycle.
   always_ff @(posedge pclk)
   begin
      float_pat <= ~float_pat;
   end
   // The device driver wins, then the board, then the pull-up.
   always_comb
   begin
      for (int i = 0; i < NPINS; i++)
      begin
         if (!pin_oe_n[i])
            pin_in[i] = pin_out[i];
         else if (board_en[i])
            pin_in[i] = board_val[i];
         else if (pullup_en[i])
            pin_in[i] = 1'b1;
         else
            pin_in[i] = float_pat[i];
      end
   end
endmodule
`default_nettype wire

/* File: test/io_port_pin_change_irq_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module io_port_pin_change_irq_tb;
   import iopc_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, clamp = 1'b0, ack = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic        pready, pslverr, err, vreq, irq;
   logic [15:0] pin_in, pin_out, pin_oe_n, pullup_en;
   logic [15:0] bval = 16'h0000, ben = 16'hffff;
   logic [1:0]  vnum;
   int          error_cnt = 0, n_checks = 0;
   // The clock toggles every 12.5 ns, half of its 25 ns period.
   always #12.5 pclk = ~pclk;
   iopc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
      .sleep_clamp(clamp), .vector_ack(ack), .vector_req(vreq),
      .vector_num(vnum), .irq(irq));
   iopc_board board (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pullup_en(pullup_en), .board_val(bval), .board_en(ben),
      .pin_in(pin_in));
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [5:0] ix, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {ix, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input string w, input logic [5:0] ix, input logic [7:0] e);
      apb(1'b0, ix, 8'h00);
      chk(w, {24'h000000, e}, rd);
   endtask
   task automatic tog(input logic [15:0] m);
      @(posedge pclk);
      bval <= bval ^ m;
      repeat (4) @(posedge pclk);
   endtask
   task automatic wvec(input logic [1:0] v);
      for (int n = 0; n < 10 && !(vreq === 1'b1 && vnum === v); n++)
         @(posedge pclk);
      chk("vector", {30'h0, v}, {30'h0, vnum});
   endtask
   task automatic vack();
      @(posedge pclk);
      ack <= 1'b1;
      @(posedge pclk);
      ack <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   task automatic t_reset();
      rdc("a_dir", IDX_PORT_A_DIR, RST_ZERO);
      rdc("a_out", IDX_PORT_A_OUTPUT, RST_ZERO);
      rdc("b_dir", IDX_PORT_B_DIR, RST_ZERO);
      rdc("b_out", IDX_PORT_B_OUTPUT, RST_ZERO);
      rdc("mask_low", IDX_MASK_LOW, RST_MASK_LOW);
      rdc("mask_high", IDX_MASK_HIGH, RST_MASK_HIGH);
      rdc("control", IDX_CORE_CONTROL, RST_ZERO);
      apb(1'b0, 6'h00, 8'h00);
      chk("slverr", 32'h1, {31'h0, err});
   endtask
   task automatic t_output();
      apb(1'b1, IDX_PORT_A_DIR, 8'hff);
      apb(1'b1, IDX_PORT_A_OUTPUT, 8'ha5);
      rdc("a_in", IDX_PORT_A_INPUT, 8'ha5);
      chk("pin_out", 32'ha5, {24'h0, pin_out[7:0]});
      chk("oe_n", 32'h00, {24'h0, pin_oe_n[7:0]});
      apb(1'b1, IDX_PORT_A_INPUT, 8'h0f);
      rdc("a_toggle", IDX_PORT_A_OUTPUT, 8'haa);
   endtask
   task automatic t_pullup();
      apb(1'b1, IDX_PORT_B_OUTPUT, 8'h0f);
      @(posedge pclk);
      chk("pullup", 32'h0f00, {16'h0, pullup_en});
      apb(1'b1, IDX_CORE_CONTROL, 8'h40);
      @(posedge pclk);
      chk("pullup_off", 32'h0, {16'h0, pullup_en});
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("pullup_rst", 32'h0, {16'h0, pullup_en});
      chk("oe_n_rst", 32'hffff, {16'h0, pin_oe_n});
      presetn <= 1'b1;
   endtask
   task automatic t_pc();
      apb(1'b1, IDX_MASK_LOW, 8'h01);
      apb(1'b1, IDX_GROUP_ENABLE, 8'h10);
      apb(1'b1, IDX_IRQ_ENABLE, 8'h20);
      apb(1'b1, IDX_CORE_STATUS, 8'h80);
      tog(16'h0001);
      rdc("flag", IDX_FLAG_STATUS, 8'h20);
      chk("irq", 32'h1, {31'h0, irq});
      wvec(VEC_PC);
      vack();
      rdc("flag_ack", IDX_FLAG_STATUS, 8'h00);
      tog(16'h0002);
      rdc("flag_mask", IDX_FLAG_STATUS, 8'h00);
      tog(16'h0001);
      apb(1'b1, IDX_FLAG_CLEAR, 8'h20);
      rdc("flag_w1c", IDX_FLAG_STATUS, 8'h00);
      chk("irq_clr", 32'h0, {31'h0, irq});
   endtask
   task automatic t_group();
      apb(1'b1, IDX_GROUP_ENABLE, 8'h20);
      tog(16'h1001);
      rdc("flag_g0", IDX_FLAG_STATUS, 8'h00);
      tog(16'h0100);
      rdc("flag_p8", IDX_FLAG_STATUS, 8'h20);
      apb(1'b1, IDX_FLAG_CLEAR, 8'h20);
   endtask
   task automatic t_ext();
      apb(1'b1, IDX_GROUP_ENABLE, 8'h10);
      apb(1'b1, IDX_EXT_CONTROL, 8'h03);
      apb(1'b1, IDX_IRQ_ENABLE, 8'h60);
      tog(16'h0005);
      wvec(VEC_EXT);
      vack();
      wvec(VEC_PC);
      vack();
      rdc("flag_both", IDX_FLAG_STATUS, 8'h00);
      apb(1'b1, IDX_EXT_CONTROL, 8'h07);
      tog(16'h0004);
      rdc("rise_on_fall", IDX_FLAG_STATUS, 8'h00);
      tog(16'h0004);
      rdc("rise", IDX_FLAG_STATUS, 8'h40);
      apb(1'b1, IDX_EXT_CONTROL, 8'h05);
      apb(1'b1, IDX_FLAG_CLEAR, 8'h40);
      tog(16'h0004);
      rdc("fall", IDX_FLAG_STATUS, 8'h40);
      apb(1'b1, IDX_FLAG_CLEAR, 8'h40);
      tog(16'h0004);
      rdc("fall_on_rise", IDX_FLAG_STATUS, 8'h00);
   endtask
   task automatic t_clamp();
      apb(1'b1, IDX_MASK_LOW, 8'h00);
      apb(1'b1, IDX_EXT_CONTROL, 8'h02);
      @(posedge pclk);
      bval <= 16'h00ff;
      repeat (4) @(posedge pclk);
      clamp <= 1'b1;
      apb(1'b1, IDX_FLAG_CLEAR, 8'h60);
      rdc("a_clamp", IDX_PORT_A_INPUT, 8'h00);
      apb(1'b1, IDX_EXT_CONTROL, 8'h03);
      rdc("a_ext", IDX_PORT_A_INPUT, 8'h04);
      apb(1'b1, IDX_EXT_CONTROL, 8'h02);
      apb(1'b1, IDX_FLAG_CLEAR, 8'h60);
      clamp <= 1'b0;
      repeat (4) @(posedge pclk);
      rdc("a_wake", IDX_PORT_A_INPUT, 8'hff);
      rdc("flag_wake", IDX_FLAG_STATUS, 8'h40);
      apb(1'b1, IDX_EXT_CONTROL, 8'h08);
      rdc("a_an1", IDX_PORT_A_INPUT, 8'hfd);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Main sequence after the reset has been held for 12 cycles.
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_output();
      t_pullup();
      t_pc();
      t_group();
      t_ext();
      t_clamp();
      finish_test();
   end
   // Watchdog cuts a hang short well beyond the expected run.
   initial
   begin
      repeat (5000) @(posedge pclk);
      error_cnt++;
      finish_test();
   end
endmodule
`default_nettype wire
